// ==== logic/xpid_decode.sv ====
// Extended pointer instruction decoder and executor.
// Assumes one instruction word per clock on instr_in with instr_valid_in, reads of data memory
// combinational via rd_addr_out / rd_data_in, and stack/PC owned by the core, driven from here by registered load, push and pop pulses.
// Assumes the core supplies the second word of a move on a later valid cycle and
// keeps return and call words away while busy_out is high.
`timescale 1ns/1ps
`default_nettype none
module xpid_decode
    import xpid_pkg::*;
(
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic ext_enable_in,
    input wire logic instr_valid_in,
    input wire logic [15:0] instr_in,
    input wire logic [20:0] pc_in,
    input wire logic [20:0] tos_in,
    input wire logic [7:0] working_register_in,
    input wire logic [7:0] program_counter_high_latch_in,
    input wire logic [4:0] program_counter_upper_latch_in,
    input wire logic [7:0] rd_data_in,
    output logic [11:0] rd_addr_out,
    output logic [11:0] ptr0_out,
    output logic [11:0] ptr1_out,
    output logic [11:0] frame_ptr_out,
    output logic pc_load_out,
    output logic [20:0] pc_value_out,
    output logic stack_push_out,
    output logic [20:0] stack_push_data_out,
    output logic stack_pop_out,
    output xpid_wr_t mem_wr_out,
    output logic busy_out,
    output logic claimed_out
);
    // ************************************************************
    // Decode
    // ************************************************************
    xpid_state_t state;
    logic [11:0] ptr [3];
    logic [7:0] move_src_data;
    logic [7:0] hi;
    logic [1:0] sel;
    logic [5:0] lit6;
    logic is_add;
    logic is_sub;
    logic is_push;
    logic is_move;
    logic is_call_through_working_register;
    logic take;
    logic [11:0] src_addr;

    // Fields are sliced for every word; the is_ strobes decide whether they mean anything
    assign hi = instr_in[15:8];
    assign sel = instr_in[7:6];
    assign lit6 = instr_in[5:0];
    // Words offered while busy belong to the running instruction and are never decoded
    // With the extension off the core's standard decoder keeps every word
    assign take = instr_valid_in && ext_enable_in && (state == XPID_IDLE);
    assign is_add = take && (hi == XPID_OP_ADD);
    assign is_sub = take && (hi == XPID_OP_SUB);
    assign is_push = take && (hi == XPID_OP_PUSH);
    assign is_move = take && (hi == XPID_OP_MOVE);
    assign is_call_through_working_register = take && (instr_in == XPID_OP_CALL_THROUGH_WORKING_REGISTER);

    // ************************************************************
    // Handshake towards the core's own decoder
    // ************************************************************
    // Claimed tells the standard decoder to stand aside for this word
    assign claimed_out = is_add || is_sub || is_push || is_move || is_call_through_working_register;
    // Busy marks the second cycle, whose word is not decoded afresh
    assign busy_out = (state != XPID_IDLE);

    // Source for both moves: frame pointer plus 7-bit offset
    // The read port is combinational, so the core must answer in the same cycle
    assign src_addr = ptr[2] + {5'h00, instr_in[6:0]};
    assign rd_addr_out = src_addr;

    // ************************************************************
    // Sequencer
    // ************************************************************
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            state <= XPID_IDLE;
        end else begin
            case (state)
                XPID_IDLE: begin
                    // Plain pointer ops and push finish in the decode cycle and stay here
                    if ((is_add || is_sub) && sel == XPID_SEL_FRAME) begin
                        state <= XPID_NOP2;
                    end else if (is_call_through_working_register) begin
                        state <= XPID_NOP2;
                    end else if (is_move) begin
                        state <= XPID_MOVE2;
                    end
                end
                // Second cycle is a no-operation while the new target is fetched
                XPID_NOP2: state <= XPID_IDLE;
                XPID_MOVE2: begin
                    // Waits for the second word; a core that never sends one stalls here
                    if (instr_valid_in) begin
                        state <= XPID_IDLE;
                    end
                end
                default: state <= XPID_IDLE;
            endcase
        end
    end

    // ************************************************************
    // Pointer file; selector 11 always means the frame pointer
    // ************************************************************
    // Selector 11 is folded onto entry 2, so only three entries ever exist
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            ptr[0] <= XPID_PTR_RESET;
            ptr[1] <= XPID_PTR_RESET;
            ptr[2] <= XPID_PTR_RESET;
        end else if (is_add) begin
            if (sel == XPID_SEL_FRAME) begin
                ptr[2] <= ptr[2] + {6'h00, lit6};
            end else begin
                ptr[sel] <= ptr[sel] + {6'h00, lit6};
            end
        end else if (is_sub) begin
            if (sel == XPID_SEL_FRAME) begin
                ptr[2] <= ptr[2] - {6'h00, lit6};
            end else begin
                ptr[sel] <= ptr[sel] - {6'h00, lit6};
            end
        end else if (is_push) begin
            ptr[2] <= ptr[2] - 12'h001;
        end
    end

    // ************************************************************
    // Pointer outputs
    // ************************************************************
    // Registered values, so the core sees an update from the next cycle on
    assign ptr0_out = ptr[0];
    assign ptr1_out = ptr[1];
    assign frame_ptr_out = ptr[2];

    // ************************************************************
    // Program counter and return stack
    // ************************************************************
    // Frame pointer is written on the same edge, so the return is seen after the update
    // pc_value_out holds between loads; only pc_load_out marks a new target
    // No status flag is kept here, so none of these paths can alter one
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            pc_load_out <= 1'b0;
            pc_value_out <= XPID_PC_RESET;
            stack_push_out <= 1'b0;
            stack_push_data_out <= XPID_PC_RESET;
            stack_pop_out <= 1'b0;
        end else begin
            pc_load_out <= 1'b0;
            stack_push_out <= 1'b0;
            stack_pop_out <= 1'b0;
            if ((is_add || is_sub) && sel == XPID_SEL_FRAME) begin
                pc_load_out <= 1'b1;
                pc_value_out <= tos_in;
                stack_pop_out <= 1'b1;
            end else if (is_call_through_working_register) begin
                stack_push_out <= 1'b1;
                stack_push_data_out <= pc_in + 21'h000002;
                pc_load_out <= 1'b1;
                pc_value_out <= {program_counter_upper_latch_in, program_counter_high_latch_in, working_register_in};
            end
        end
    end

    // ************************************************************
    // Data memory writes: push and the two moves
    // ************************************************************
    // Source byte is captured in the first word so a changing frame pointer cannot skew it
    // Reads in the indirect window give zero instead of following a pointer
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            move_src_data <= 8'h00;
        end else if (is_move) begin
            if (src_addr >= XPID_INDF_LO && src_addr <= XPID_INDF_HI) begin
                move_src_data <= 8'h00;
            end else begin
                move_src_data <= rd_data_in;
            end
        end
    end

    // ************************************************************
    // Move bookkeeping
    // ************************************************************
    // First word kept so the second cycle knows which destination form applies
    logic [15:0] move_first;
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            move_first <= 16'h0000;
        end else if (is_move) begin
            move_first <= instr_in;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            mem_wr_out <= '0;
        end else begin
            mem_wr_out <= '0;
            // Push writes at the old frame pointer while the decrement lands on the same edge
            // A second move word without the 1111 prefix ends the move but writes nothing
            if (is_push) begin
                mem_wr_out <= '{en: 1'b1, addr: ptr[2], data: instr_in[7:0]};
            end else if (state == XPID_MOVE2 && instr_valid_in
                         && instr_in[15:12] == XPID_SECOND_PREFIX) begin
                mem_wr_out.en <= 1'b1;
                mem_wr_out.data <= move_src_data;
                // Indexed form adds the offset to the frame pointer as it stands now
                if (move_first[XPID_MOVE_SEL_BIT]) begin
                    mem_wr_out.addr <= ptr[2] + {5'h00, instr_in[6:0]};
                end else begin
                    mem_wr_out.addr <= instr_in[11:0];
                end
            end
        end
    end
endmodule : xpid_decode
`default_nettype wire

// ==== logic/xpid_pkg.sv ====
// Package for the extended pointer instruction decoder: opcodes, field layout, timing.
// Assumes a core that presents one instruction word per instruction cycle.
// How it works
// - Pointer add: add 6-bit literal to selected pointer, one cycle.
// - Pointer subtract: subtract 6-bit literal from selected pointer, one cycle.
// - Selector 11 means frame pointer with return, never a fourth pointer.
// - Frame add and return: add literal to frame pointer, return, two cycles.
// - Return variants load program counter from top of stack after pointer update.
// - Second cycle of return variants is a no-operation while target fetches.
// - Frame subtract and return: subtract literal, return through top of stack, two cycles.
// - Literal push: store 8-bit literal at frame pointer, decrement it, one cycle.
// - Call through working register: fixed opcode, two cycles.
// - Indexed moves: two words, two cycles, bit 7 picks absolute or indexed destination.
// - Call pushes next address; PC low from working register, upper bytes from latches.
// - Absolute move: source frame pointer plus 7-bit offset, destination 12-bit literal.
// - Indexed move reading an indirect-addressing register moves zero.
package xpid_pkg;
    localparam logic [7:0] XPID_OP_ADD = 8'he8;
    localparam logic [7:0] XPID_OP_SUB = 8'he9;
    localparam logic [7:0] XPID_OP_PUSH = 8'hea;
    localparam logic [7:0] XPID_OP_MOVE = 8'heb;
    localparam logic [15:0] XPID_OP_CALL_THROUGH_WORKING_REGISTER = 16'h0014;
    localparam logic [3:0] XPID_SECOND_PREFIX = 4'hf;
    localparam logic [1:0] XPID_SEL_FRAME = 2'h3;
    localparam int XPID_MOVE_SEL_BIT = 7;
    // Indirect-addressing registers sit in this window of the data space
    localparam logic [11:0] XPID_INDF_LO = 12'hfdb;
    localparam logic [11:0] XPID_INDF_HI = 12'hfef;
    localparam logic [11:0] XPID_PTR_RESET = 12'h000;
    localparam logic [20:0] XPID_PC_RESET = 21'h000000;

    typedef enum logic [1:0] {
        XPID_IDLE = 2'b00,
        XPID_NOP2 = 2'b01,
        XPID_MOVE2 = 2'b10
    } xpid_state_t;

    // One data-memory write request towards the datapath
    typedef struct packed {
        logic en;
        logic [11:0] addr;
        logic [7:0] data;
    } xpid_wr_t;
endpackage : xpid_pkg

// ==== test/testbench.sv ====
// Self-checking bench: hand corner cases, then seeded random words with a reference model.
// Assumes the core model supplies read data and top of stack.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import xpid_pkg::*;
    logic mclk_in = 1'b0, rst_in = 1'b1, ext_enable_in = 1'b1, instr_valid_in = 1'b0;
    logic [15:0] instr_in = 16'h0000;
    logic [20:0] pc_in = 21'h000100, tos_in, pc_value_out, stack_push_data_out, t;
    logic [7:0] working_register_in = 8'h00, program_counter_high_latch_in = 8'h12, rd_data_in;
    logic [4:0] program_counter_upper_latch_in = 5'h03;
    logic [11:0] rd_addr_out, ptr0_out, ptr1_out, frame_ptr_out, src;
    logic pc_load_out, stack_push_out, stack_pop_out, busy_out, claimed_out, go, ret, cl, pu, mv;
    xpid_wr_t mem_wr_out;
    logic [11:0] ptr [3] = '{3{XPID_PTR_RESET}};
    logic [1:0] i;
    int miscompares = 0, checked = 0;
    integer seed = 32'hd33ab511, r;
    always #25 mclk_in = ~mclk_in;
    xpid_decode dut (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .ext_enable_in(ext_enable_in),
        .instr_valid_in(instr_valid_in),
        .instr_in(instr_in),
        .pc_in(pc_in),
        .tos_in(tos_in),
        .working_register_in(working_register_in),
        .program_counter_high_latch_in(program_counter_high_latch_in),
        .program_counter_upper_latch_in(program_counter_upper_latch_in),
        .rd_data_in(rd_data_in),
        .rd_addr_out(rd_addr_out),
        .ptr0_out(ptr0_out),
        .ptr1_out(ptr1_out),
        .frame_ptr_out(frame_ptr_out),
        .pc_load_out(pc_load_out),
        .pc_value_out(pc_value_out),
        .stack_push_out(stack_push_out),
        .stack_push_data_out(stack_push_data_out),
        .stack_pop_out(stack_pop_out),
        .mem_wr_out(mem_wr_out),
        .busy_out(busy_out),
        .claimed_out(claimed_out)
    );
    xpid_core_model core (.mclk_in(mclk_in), .rd_addr_in(rd_addr_out), .push_in(stack_push_out),
        .push_data_in(stack_push_data_out), .pop_in(stack_pop_out), .rd_data_out(rd_data_in), .tos_out(tos_in));
    task cmp(input string name, input logic [20:0] exp, input logic [20:0] got);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : cmp
    // Indirect-addressing window reads back as zero
    function automatic logic [7:0] exp_read(input logic [11:0] a);
        return (a >= XPID_INDF_LO && a <= XPID_INDF_HI) ? 8'h00 : a[7:0] ^ 8'h5a;
    endfunction : exp_read
    task run(input logic [15:0] w, input logic [15:0] w2);
        @(negedge mclk_in);
        instr_in = w;
        instr_valid_in = 1'b1;
        pc_in = 21'($random(seed));
        working_register_in = 8'($random(seed));
        program_counter_high_latch_in = 8'($random(seed));
        program_counter_upper_latch_in = 5'($random(seed));
        go = ext_enable_in && (w[15:10] == 6'h3a || w == XPID_OP_CALL_THROUGH_WORKING_REGISTER);
        ret = go && w[15:9] == 7'h74 && w[7:6] == XPID_SEL_FRAME;
        cl = go && w == XPID_OP_CALL_THROUGH_WORKING_REGISTER;
        pu = go && w[15:8] == XPID_OP_PUSH;
        mv = go && w[15:8] == XPID_OP_MOVE;
        t = tos_in;
        src = ptr[2] + 12'(w[6:0]);
        i = ret ? 2'h2 : w[7:6];
        if (go && w[15:9] == 7'h74)
            ptr[i] = w[8] ? ptr[i] - 12'(w[5:0]) : ptr[i] + 12'(w[5:0]);
        #1 cmp("claimed", 21'(go), 21'(claimed_out));
        cmp("rd_addr", 21'(src), 21'(rd_addr_out));
        @(negedge mclk_in);
        instr_in = w2;
        instr_valid_in = mv;
        cmp("busy", 21'(ret || cl || mv), 21'(busy_out));
        cmp("pc_load", 21'(ret || cl), 21'(pc_load_out));
        if (ret || cl)
            cmp("pc_value", cl ? {program_counter_upper_latch_in, program_counter_high_latch_in, working_register_in} : t, pc_value_out);
        cmp("pop", 21'(ret), 21'(stack_pop_out));
        cmp("push", 21'(cl), 21'(stack_push_out));
        if (cl)
            cmp("push_data", pc_in + 21'h000002, stack_push_data_out);
        cmp("mem_wr", pu ? {1'b1, ptr[2], w[7:0]} : 21'h0, mem_wr_out);
        if (pu)
            ptr[2] = ptr[2] - 12'h001;
        cmp("ptr0", 21'(ptr[0]), 21'(ptr0_out));
        cmp("ptr1", 21'(ptr[1]), 21'(ptr1_out));
        cmp("frame", 21'(ptr[2]), 21'(frame_ptr_out));
        if (mv) begin
            @(negedge mclk_in);
            instr_valid_in = 1'b0;
            cmp("move", w2[15:12] != XPID_SECOND_PREFIX ? 21'h0 : {1'b1, w[7] ? ptr[2] + 12'(w2[6:0]) :
                w2[11:0], exp_read(src)}, mem_wr_out);
        end
    endtask : run
    task results;
        $display("Comparisons %0d, mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : results
    initial begin
        repeat (6) @(posedge mclk_in);
        @(negedge mclk_in);
        rst_in = 1'b0;
        // Frame lands on the indirect window so the next move reads zero
        run(16'he9a5, 16'h0000);
        run(16'heb00, 16'hf123);
        run(16'heb85, 16'hf0ff);
        run(16'he8c5, 16'h0000);
        run(16'he9c1, 16'h0000);
        run(XPID_OP_CALL_THROUGH_WORKING_REGISTER, 16'h0000);
        run(16'hea77, 16'h0000);
        run(16'h0000, 16'h0000);
        repeat (400) begin
            r = $random(seed);
            ext_enable_in = r[31:29] != 3'h0;
            run(r[28:26] == 3'h0 ? XPID_OP_CALL_THROUGH_WORKING_REGISTER : {6'h3a, r[9:0]}, {r[25] ? 4'hf : r[24:21], r[20:9]});
        end
        results();
    end
endmodule : testbench
`default_nettype wire

// ==== test/xpid_core_model.sv ====
// Core-side model: combinational data-memory read port and the top-of-stack entry.
// Assumes the decoder's registered one-cycle stack pulses.
`timescale 1ns/1ps
`default_nettype none
module xpid_core_model (
    input wire logic mclk_in,
    input wire logic [11:0] rd_addr_in,
    input wire logic push_in,
    input wire logic [20:0] push_data_in,
    input wire logic pop_in,
    output logic [7:0] rd_data_out,
    output logic [20:0] tos_out = 21'h0abcde
);
    // Data follows the low address byte, so a wrong low byte of the source address shows as wrong data
    assign rd_data_out = rd_addr_in[7:0] ^ 8'h5a;
    always @(posedge mclk_in) begin
        if (push_in)
            tos_out <= push_data_in;
        else if (pop_in)
            tos_out <= tos_out ^ 21'h150155;
    end
endmodule : xpid_core_model
`default_nettype wire

// ==== test/xpid_decode_sva.sv ====
// Checker for the extended pointer instruction decoder, bound to its ports.
// Assumes the registered one-cycle answer described for the decoder.
`timescale 1ns/1ps
`default_nettype none
module xpid_decode_sva
    import xpid_pkg::*;
(
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic ext_enable_in,
    input wire logic [15:0] instr_in,
    input wire logic [20:0] pc_in,
    input wire logic [20:0] tos_in,
    input wire logic [11:0] ptr0_out,
    input wire logic [11:0] frame_ptr_out,
    input wire logic pc_load_out,
    input wire logic [20:0] pc_value_out,
    input wire logic stack_push_out,
    input wire logic [20:0] stack_push_data_out,
    input wire logic stack_pop_out,
    input wire xpid_wr_t mem_wr_out,
    input wire logic busy_out,
    input wire logic claimed_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (rst_in);
    property p_add; claimed_out && instr_in[15:6] == {XPID_OP_ADD, 2'h0} |=>
        ptr0_out == $past(ptr0_out) + 12'($past(instr_in[5:0])); endproperty
    a_add: assert property (p_add) else $error("pointer add wrong");
    property p_sub; claimed_out && instr_in[15:6] == {XPID_OP_SUB, 2'h2} |=>
        frame_ptr_out == $past(frame_ptr_out) - 12'($past(instr_in[5:0])); endproperty
    a_sub: assert property (p_sub) else $error("pointer subtract wrong");
    property p_rfr; claimed_out && instr_in[15:6] == {XPID_OP_ADD, XPID_SEL_FRAME} |=>
        frame_ptr_out == $past(frame_ptr_out) + 12'($past(instr_in[5:0])); endproperty
    a_rfr: assert property (p_rfr) else $error("frame add wrong");
    property p_ret; claimed_out && instr_in[15:9] == 7'h74 && instr_in[7:6] == XPID_SEL_FRAME |=>
        pc_load_out && stack_pop_out && busy_out && pc_value_out == $past(tos_in); endproperty
    a_ret: assert property (p_ret) else $error("return wrong");
    property p_nop; pc_load_out && busy_out |-> !claimed_out ##1 !pc_load_out && !mem_wr_out.en; endproperty
    a_nop: assert property (p_nop) else $error("second cycle not idle");
    property p_push; claimed_out && instr_in[15:8] == XPID_OP_PUSH |=> mem_wr_out.en &&
        mem_wr_out.addr == $past(frame_ptr_out) && mem_wr_out.data == $past(instr_in[7:0]) &&
        frame_ptr_out == $past(frame_ptr_out) - 12'h001; endproperty
    a_push: assert property (p_push) else $error("push wrong");
    property p_call; claimed_out && instr_in == XPID_OP_CALL_THROUGH_WORKING_REGISTER |=> stack_push_out && pc_load_out &&
        busy_out && stack_push_data_out == $past(pc_in) + 21'h000002; endproperty
    a_call: assert property (p_call) else $error("call wrong");
    property p_move; claimed_out && instr_in[15:8] == XPID_OP_MOVE |=> busy_out ##1 !busy_out; endproperty
    a_move: assert property (p_move) else $error("move length wrong");
    property p_off; !ext_enable_in |-> !claimed_out; endproperty
    a_off: assert property (p_off) else $error("claimed while disabled");
endmodule : xpid_decode_sva
bind xpid_decode xpid_decode_sva u_sva (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .ext_enable_in(ext_enable_in),
    .instr_in(instr_in),
    .pc_in(pc_in),
    .tos_in(tos_in),
    .ptr0_out(ptr0_out),
    .frame_ptr_out(frame_ptr_out),
    .pc_load_out(pc_load_out),
    .pc_value_out(pc_value_out),
    .stack_push_out(stack_push_out),
    .stack_push_data_out(stack_push_data_out),
    .stack_pop_out(stack_pop_out),
    .mem_wr_out(mem_wr_out),
    .busy_out(busy_out),
    .claimed_out(claimed_out)
);
`default_nettype wire
